// >>> src/alprr_regs.vh
// Purpose: Offsets, field positions and reset values of the alarm limit, hysteresis, power and reset registers
// Assumes: Register addresses are the 7-bit register pointer of the serial port
// Notes: Definitions only
`ifndef ALPRR_REGS_VH
`define ALPRR_REGS_VH
`define ALPRR_ADDR_W 7
`define ALPRR_DATA_W 16
`define ALPRR_OFF_R1_UPPER 7'h64
`define ALPRR_OFF_R1_LOWER 7'h65
`define ALPRR_OFF_R2_UPPER 7'h66
`define ALPRR_OFF_R2_LOWER 7'h67
`define ALPRR_OFF_HYS_CH01 7'h68
`define ALPRR_OFF_HYS_CH23 7'h69
`define ALPRR_OFF_HYS_TEMP 7'h6A
`define ALPRR_OFF_POWER 7'h6B
`define ALPRR_OFF_MODEL_ID 7'h6C
`define ALPRR_OFF_SOFT_RST 7'h7C
`define ALPRR_RST_UPPER 12'h7FF
`define ALPRR_RST_LOWER 12'h800
`define ALPRR_RST_HYS_CH 16'h0810
`define ALPRR_RST_HYS_TEMP 16'h2108
`define ALPRR_RST_POWER 16'h0000
`define ALPRR_MASK_LIMIT 16'h0FFF
`define ALPRR_MASK_HYS_CH 16'h7FFE
`define ALPRR_MASK_HYS_TEMP 16'h7FFF
`define ALPRR_MASK_POWER 16'h7FFE
`define ALPRR_SPI_RESET_KEY 16'h6600
`define ALPRR_BIT_CONV_ON 14
`define ALPRR_BIT_REFBUF_ON 13
`define ALPRR_DAC_MSB 12
`define ALPRR_DAC_LSB 1
`endif

// >>> src/alprr_bank.v
// Purpose: Alarm limit, hysteresis, power enable, identity and software reset registers
// Assumes: Serial port front end delivers decoded register accesses on clk; I2C mode is a plain input
// Notes: Software reset spares the DAC data, latch and clear registers held elsewhere
// Notes: Field outputs trail the stored words by one clock, the limit order flags as well
//
// What this block does
// - Remote sensor A upper limit at 64h, 12 bits, reset 07FFh.
// - Remote sensor A lower limit at 65h, 12 bits, reset 0800h.
// - Remote sensor B upper limit at 66h, 12 bits, reset 07FFh.
// - Remote sensor B lower limit at 67h, 12 bits, reset 0800h.
// - Limit bits 15..12 read zero and ignore writes.
// - Register 68h resets 0810h, channel 0 hysteresis 14..8, channel 1 7..1.
// - Register 69h resets 0810h, channel 2 hysteresis 14..8, channel 3 7..1.
// - Register 6Ah resets 2108h, five-bit sensor B, A, local hysteresis fields.
// - Temperature hysteresis counts one degree per step, 0 to 31, low bits zero.
// - Each alarm detector uses its own hysteresis value from these registers.
// - Power register 6Bh resets 0000h, all blocks start in low power.
// - Bit 14 set runs the converter, clear keeps it in low power.
// - Bit 13 set powers the reference buffer, clear keeps it off.
// - Bits 12..1 enable DAC0..DAC11; clear parks that DAC output to ground.
// - Read-only identity register at 6Ch returns fixed code; writes ignored.
// - Software reset via 7Ch restores defaults except DAC data, latch, clear.
// - Hardware reset restores every register including DAC data, latch, clear.
// - In SPI mode only a write of 6600h to 7Ch resets.
// - In I2C mode any write to 7Ch resets; reads return discardable data.
// - In I2C mode the reset register is one byte wide.
// - I2C reset write is start, address, 7Ch, one byte, stop, each acknowledged.
// - Upper limit must exceed lower, otherwise the input alarm stays flagged.
`timescale 1ns/10ps
`include "alprr_regs.vh"
module alprr_bank #(
    parameter [15:0] MODEL_CODE = 16'hA5C3 // Arbitrary value
)(
    input wire clk,
    input wire resetn,
    input wire i2c_mode,
    input wire wr_en,
    input wire rd_en,
    input wire [6:0] reg_addr,
    input wire [15:0] wr_data,
    output reg [15:0] rd_data,
    output reg rd_valid,
    output reg soft_reset_pulse,
    output reg hard_reset_pulse,
    output reg [11:0] remote_a_upper_limit_field,
    output reg [11:0] remote_a_lower_limit_field,
    output reg [11:0] remote_b_upper_limit_field,
    output reg [11:0] remote_b_lower_limit_field,
    output reg limit_order_bad_a,
    output reg limit_order_bad_b,
    output reg [6:0] chan0_hysteresis,
    output reg [6:0] chan1_hysteresis,
    output reg [6:0] chan2_hysteresis,
    output reg [6:0] chan3_hysteresis,
    output reg [7:0] remote_b_hysteresis,
    output reg [7:0] remote_a_hysteresis,
    output reg [7:0] local_temp_hysteresis,
    output reg converter_power_on,
    output reg refbuf_power_on,
    output reg [11:0] dac_power_on
);

    // Stored words; spare bits are kept at zero by the write masks
    reg [11:0] r1_upper_reg;
    reg [11:0] r1_lower_reg;
    reg [11:0] r2_upper_reg;
    reg [11:0] r2_lower_reg;
    reg [15:0] hys_ch01_reg;
    reg [15:0] hys_ch23_reg;
    reg [15:0] hys_temp_reg;
    reg [15:0] power_reg;
    // Next values of the stored words
    reg [11:0] r1_upper_next;
    reg [11:0] r1_lower_next;
    reg [11:0] r2_upper_next;
    reg [11:0] r2_lower_next;
    reg [15:0] hys_ch01_next;
    reg [15:0] hys_ch23_next;
    reg [15:0] hys_temp_next;
    reg [15:0] power_next;
    reg [15:0] rd_next;
    reg srst_req;
    reg seen_reset_reg;
    wire wr_soft;
    wire clear_all;
    // Write strobes, one per stored register
    wire wr_r1_upper;
    wire wr_r1_lower;
    wire wr_r2_upper;
    wire wr_r2_lower;
    wire wr_hys_ch01;
    wire wr_hys_ch23;
    wire wr_hys_temp;
    wire wr_power;
    integer i;

    // Signed compare: limits are twos complement temperatures
    function limit_bad;
        input [11:0] upper;
        input [11:0] lower;
        begin
            limit_bad = ($signed(upper) <= $signed(lower));
        end
    endfunction

    // One address compare shared by every write strobe and the reset trigger
    function addr_hit;
        input [6:0] addr;
        input [6:0] offset;
        begin
            addr_hit = (addr == offset);
        end
    endfunction

    // Temperature hysteresis is whole degrees; the three fraction bits stay zero
    // The detectors compare in eighth-degree units, so the field is shifted up here
    function [7:0] whole_degrees;
        input [4:0] steps;
        begin
            whole_degrees = {steps, 3'h0};
        end
    endfunction

    // Reset key check differs by port mode; I2C sees only one byte so any value counts
    assign wr_soft = wr_en && addr_hit(reg_addr, `ALPRR_OFF_SOFT_RST);
    always @*
    begin
        srst_req = 1'b0;
        if (wr_soft)
        begin
            if (i2c_mode)
                srst_req = 1'b1;
            else
                srst_req = (wr_data == `ALPRR_SPI_RESET_KEY);
        end
    end

    // Software reset clears this bank in the same edge as the write
    assign clear_all = ~resetn | srst_req;

    // Write strobes; the reset address is decoded apart because its data decides whether it acts
    assign wr_r1_upper = wr_en && addr_hit(reg_addr, `ALPRR_OFF_R1_UPPER);
    assign wr_r1_lower = wr_en && addr_hit(reg_addr, `ALPRR_OFF_R1_LOWER);
    assign wr_r2_upper = wr_en && addr_hit(reg_addr, `ALPRR_OFF_R2_UPPER);
    assign wr_r2_lower = wr_en && addr_hit(reg_addr, `ALPRR_OFF_R2_LOWER);
    assign wr_hys_ch01 = wr_en && addr_hit(reg_addr, `ALPRR_OFF_HYS_CH01);
    assign wr_hys_ch23 = wr_en && addr_hit(reg_addr, `ALPRR_OFF_HYS_CH23);
    assign wr_hys_temp = wr_en && addr_hit(reg_addr, `ALPRR_OFF_HYS_TEMP);
    assign wr_power = wr_en && addr_hit(reg_addr, `ALPRR_OFF_POWER);

    // Next values: any reset beats a write in the same cycle, then a masked write, else hold
    always @*
    begin
        // Hold is the default so no path leaves a latch
        r1_upper_next = r1_upper_reg;
        r1_lower_next = r1_lower_reg;
        r2_upper_next = r2_upper_reg;
        r2_lower_next = r2_lower_reg;
        hys_ch01_next = hys_ch01_reg;
        hys_ch23_next = hys_ch23_reg;
        hys_temp_next = hys_temp_reg;
        power_next = power_reg;
        if (clear_all)
        begin
            r1_upper_next = `ALPRR_RST_UPPER;
            r1_lower_next = `ALPRR_RST_LOWER;
            r2_upper_next = `ALPRR_RST_UPPER;
            r2_lower_next = `ALPRR_RST_LOWER;
            hys_ch01_next = `ALPRR_RST_HYS_CH;
            hys_ch23_next = `ALPRR_RST_HYS_CH;
            hys_temp_next = `ALPRR_RST_HYS_TEMP;
            power_next = `ALPRR_RST_POWER;
        end
        else
        begin
            // Limit bits 15..12 are never stored, so they cannot be written
            if (wr_r1_upper)
                r1_upper_next = wr_data[11:0];
            if (wr_r1_lower)
                r1_lower_next = wr_data[11:0];
            if (wr_r2_upper)
                r2_upper_next = wr_data[11:0];
            if (wr_r2_lower)
                r2_lower_next = wr_data[11:0];
            // Spare bits are masked on the way in, so reads return zero there
            if (wr_hys_ch01)
                hys_ch01_next = wr_data & `ALPRR_MASK_HYS_CH;
            if (wr_hys_ch23)
                hys_ch23_next = wr_data & `ALPRR_MASK_HYS_CH;
            if (wr_hys_temp)
                hys_temp_next = wr_data & `ALPRR_MASK_HYS_TEMP;
            if (wr_power)
                power_next = wr_data & `ALPRR_MASK_POWER;
            // Identity and unmapped writes match no strobe and fall away
        end
    end

    // Storage flops; reset and write priority live in the next-value logic above
    // Keeping the flops bare lets hardware and software reset share one path
    always @(posedge clk)
    begin
        r1_upper_reg <= r1_upper_next;
        r1_lower_reg <= r1_lower_next;
        r2_upper_reg <= r2_upper_next;
        r2_lower_reg <= r2_lower_next;
        hys_ch01_reg <= hys_ch01_next;
        hys_ch23_reg <= hys_ch23_next;
        hys_temp_reg <= hys_temp_next;
        power_reg <= power_next;
    end

    // Read mux; reserved bits come back zero
    // Identity word is a parameter so a new revision needs no new logic
    always @*
    begin
        case (reg_addr)
            `ALPRR_OFF_R1_UPPER: rd_next = {4'h0, r1_upper_reg};
            `ALPRR_OFF_R1_LOWER: rd_next = {4'h0, r1_lower_reg};
            `ALPRR_OFF_R2_UPPER: rd_next = {4'h0, r2_upper_reg};
            `ALPRR_OFF_R2_LOWER: rd_next = {4'h0, r2_lower_reg};
            `ALPRR_OFF_HYS_CH01: rd_next = hys_ch01_reg;
            `ALPRR_OFF_HYS_CH23: rd_next = hys_ch23_reg;
            `ALPRR_OFF_HYS_TEMP: rd_next = hys_temp_reg;
            `ALPRR_OFF_POWER: rd_next = power_reg;
            `ALPRR_OFF_MODEL_ID: rd_next = MODEL_CODE;
            default: rd_next = 16'h0000; // Reset register reads are undefined; zero chosen
        endcase
    end

    // Read answer registered one cycle after the strobe
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= rd_en;
            if (rd_en)
                rd_data <= rd_next;
        end
    end

    // Reset pulses so the DAC side knows which reset to honour; DAC data is kept on soft reset
    // Only a release of resetn raises the hard pulse; a soft reset never does
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            seen_reset_reg <= 1'b1;
            soft_reset_pulse <= 1'b0;
            hard_reset_pulse <= 1'b0;
        end
        else
        begin
            seen_reset_reg <= 1'b0;
            hard_reset_pulse <= seen_reset_reg;
            soft_reset_pulse <= srst_req;
        end
    end

    // Limit fields and window order checks to the alarm detectors, one flop after storage
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            remote_a_upper_limit_field <= `ALPRR_RST_UPPER;
            remote_a_lower_limit_field <= `ALPRR_RST_LOWER;
            remote_b_upper_limit_field <= `ALPRR_RST_UPPER;
            remote_b_lower_limit_field <= `ALPRR_RST_LOWER;
            limit_order_bad_a <= 1'b0;
            limit_order_bad_b <= 1'b0;
        end
        else
        begin
            remote_a_upper_limit_field <= r1_upper_reg;
            remote_a_lower_limit_field <= r1_lower_reg;
            remote_b_upper_limit_field <= r2_upper_reg;
            remote_b_lower_limit_field <= r2_lower_reg;
            // A misordered window forces that input's alarm on
            limit_order_bad_a <= limit_bad(r1_upper_reg, r1_lower_reg);
            limit_order_bad_b <= limit_bad(r2_upper_reg, r2_lower_reg);
        end
    end

    // Channel hysteresis in converter steps, one value per alarm detector
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            chan0_hysteresis <= 7'h00;
            chan1_hysteresis <= 7'h00;
            chan2_hysteresis <= 7'h00;
            chan3_hysteresis <= 7'h00;
        end
        else
        begin
            chan0_hysteresis <= hys_ch01_reg[14:8];
            chan1_hysteresis <= hys_ch01_reg[7:1];
            chan2_hysteresis <= hys_ch23_reg[14:8];
            chan3_hysteresis <= hys_ch23_reg[7:1];
        end
    end

    // Temperature hysteresis for the sensor detectors
    // Zero for one clock after reset, then the register defaults show through
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            remote_b_hysteresis <= 8'h00;
            remote_a_hysteresis <= 8'h00;
            local_temp_hysteresis <= 8'h00;
        end
        else
        begin
            remote_b_hysteresis <= whole_degrees(hys_temp_reg[14:10]);
            remote_a_hysteresis <= whole_degrees(hys_temp_reg[9:5]);
            local_temp_hysteresis <= whole_degrees(hys_temp_reg[4:0]);
        end
    end

    // Power switches: a cleared bit keeps that block in low power
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            converter_power_on <= 1'b0;
            refbuf_power_on <= 1'b0;
            dac_power_on <= 12'h000;
        end
        else
        begin
            converter_power_on <= power_reg[`ALPRR_BIT_CONV_ON];
            refbuf_power_on <= power_reg[`ALPRR_BIT_REFBUF_ON];
            // Bit 12 is DAC0, bit 1 is DAC11; one bit each so a channel parks alone
            for (i = 0; i < 12; i = i + 1)
                dac_power_on[i] <= power_reg[`ALPRR_DAC_MSB - i];
        end
    end

endmodule

// >>> tb/alprr_bank_asserts.sv
// Purpose: Port-level checks of the alarm limit and power register bank
// Assumes: Strobes last one clock and never rise together
// Notes: Field outputs trail the stored register by one clock
`timescale 1ns/10ps
module alprr_bank_asserts #(
    parameter [15:0] MODEL_CODE = 16'hA5C3
)(
    input wire clk,
    input wire resetn,
    input wire i2c_mode,
    input wire wr_en,
    input wire rd_en,
    input wire [6:0] reg_addr,
    input wire [15:0] wr_data,
    input wire [15:0] rd_data,
    input wire rd_valid,
    input wire soft_reset_pulse,
    input wire converter_power_on
);
    // One clock domain, so clock and reset are named once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire rst_wr = wr_en && reg_addr == 7'h7C;
    // Read answers and register contents
    AST_RD_ANSWER: assert property (rd_en |=> rd_valid) else $error("read unanswered");
    AST_RD_QUIET: assert property (!rd_en |=> !rd_valid) else $error("stray read valid");
    AST_ID_CODE: assert property (rd_en && reg_addr == 7'h6C |=> rd_data == MODEL_CODE)
        else $error("bad id");
    AST_LIM_TOP: assert property (rd_en && reg_addr[6:2] == 5'h19 |=> rd_data[15:12] == 4'h0)
        else $error("limit top");
    AST_HYS_EDGE: assert property (rd_en && reg_addr[6:1] == 6'h34 |=> !rd_data[15] && !rd_data[0])
        else $error("hys spare");
    // Reset trigger decode differs by port mode
    AST_SPI_KEY: assert property (
        !i2c_mode && rst_wr |=> soft_reset_pulse == ($past(wr_data) == 16'h6600)) else $error("spi key");
    AST_I2C_ANY: assert property (i2c_mode && rst_wr |=> soft_reset_pulse)
        else $error("i2c reset missed");
    AST_NO_RST: assert property (!rst_wr |=> !soft_reset_pulse) else $error("stray soft reset");
    AST_CONV_BIT: assert property (
        wr_en && reg_addr == 7'h6B ##1 !rst_wr |=> converter_power_on == $past(wr_data[14], 2))
        else $error("converter enable");
    COV_SPI_KEY: cover property (rst_wr && !i2c_mode && wr_data == 16'h6600);
    COV_I2C_RST: cover property (rst_wr && i2c_mode);
    COV_ID_READ: cover property (rd_en && reg_addr == 7'h6C);
endmodule
bind alprr_bank alprr_bank_asserts #(.MODEL_CODE(MODEL_CODE)) i_alprr_bank_asserts (.clk(clk), .resetn(resetn),
    .i2c_mode(i2c_mode), .wr_en(wr_en), .rd_en(rd_en), .reg_addr(reg_addr), .wr_data(wr_data), .rd_data(rd_data),
    .rd_valid(rd_valid), .soft_reset_pulse(soft_reset_pulse), .converter_power_on(converter_power_on));

// >>> tb/alprr_host.sv
// Purpose: Host side of the decoded register port
// Assumes: One strobe per request, read answer one clock later
// Notes: Released address and data lines show the inverse of the last value
`timescale 1ns/10ps
module alprr_host (
    input wire clk,
    output reg wr_en = 1'b0,
    output reg rd_en = 1'b0,
    output reg [6:0] reg_addr = 7'h00,
    output reg [15:0] wr_data = 16'h0000,
    input wire [15:0] rd_data,
    input wire rd_valid
);
    // Whole word per write; the reset byte rides in the low bits
    task wr(input [6:0] a, input [15:0] d);
    begin
        @(posedge clk);
        wr_en <= 1'b1;
        reg_addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        reg_addr <= ~a;
        wr_data <= ~d;
    end
    endtask
    // Data only counts when valid; reset register reads are never used
    task rd(input [6:0] a, output [15:0] d);
    begin
        @(posedge clk);
        rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = (rd_valid === 1'b1) ? rd_data : 16'hXXXX;
    end
    endtask
endmodule

// >>> tb/alprr_bank_tb.sv
// Purpose: Self-checking bench for the alarm limit and power register bank
// Assumes: 10 MHz clock, synchronous active-low reset
// Notes: Expected words come from the register table, not from the design
`timescale 1ns/10ps
module alprr_bank_tb;
    localparam [15:0] CODE = 16'h5A3C; // Arbitrary value
    localparam [143:0] RST_T = {CODE, 64'h0000_2108_0810_0810, 64'h0800_07FF_0800_07FF};
    localparam [143:0] MSK_T = {CODE, 64'h7FFE_7FFF_7FFE_7FFE, 64'h0FFF_0FFF_0FFF_0FFF};
    reg clk;
    reg resetn;
    reg i2c_mode;
    wire wr_en, rd_en, rd_valid, srp, hrp, conv_on, ref_on, bad_a, bad_b;
    wire [6:0] reg_addr, ch0, ch1, ch2, ch3;
    wire [15:0] wr_data, rd_data;
    wire [11:0] ua, la, ub, lb, dac_on;
    wire [7:0] hb, ha, hl;
    integer bad_count;
    integer check_count;
    integer i;
    reg [15:0] d;
    alprr_bank #(.MODEL_CODE(CODE)) i_alprr_bank (.clk(clk), .resetn(resetn), .i2c_mode(i2c_mode), .wr_en(wr_en),
        .rd_en(rd_en), .reg_addr(reg_addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
        .soft_reset_pulse(srp), .hard_reset_pulse(hrp), .remote_a_upper_limit_field(ua),
        .remote_a_lower_limit_field(la), .remote_b_upper_limit_field(ub), .remote_b_lower_limit_field(lb),
        .limit_order_bad_a(bad_a), .limit_order_bad_b(bad_b), .chan0_hysteresis(ch0), .chan1_hysteresis(ch1),
        .chan2_hysteresis(ch2), .chan3_hysteresis(ch3), .remote_b_hysteresis(hb), .remote_a_hysteresis(ha),
        .local_temp_hysteresis(hl), .converter_power_on(conv_on), .refbuf_power_on(ref_on), .dac_power_on(dac_on));
    alprr_host i_alprr_host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .reg_addr(reg_addr), .wr_data(wr_data),
        .rd_data(rd_data), .rd_valid(rd_valid));
    // Compare four-state so an unknown never matches
    task check(input [8*8-1:0] nm, input [23:0] seen, input [23:0] exp);
    begin
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            bad_count = bad_count + 1;
            $display("ERROR %0s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    task finish_test;
    begin
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Run needs under a hundred clocks; this allows fifty times that
    initial
    begin
        #500000;
        bad_count = bad_count + 1;
        finish_test;
    end
    initial
    begin
        bad_count = 0;
        check_count = 0;
        resetn = 1'b0;
        i2c_mode = 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1 check("hardrst", hrp, 1'b1);
        for (i = 0; i < 9; i = i + 1)
        begin
            i_alprr_host.rd(7'h64 + i[6:0], d);
            check("default", d, RST_T[16*i +: 16]);
        end
        // All ones exposes every reserved bit and the read-only word
        for (i = 0; i < 9; i = i + 1)
        begin
            i_alprr_host.wr(7'h64 + i[6:0], 16'hFFFF);
            i_alprr_host.rd(7'h64 + i[6:0], d);
            check("masked", d, MSK_T[16*i +: 16]);
        end
        i_alprr_host.wr(7'h68, 16'h0304);
        i_alprr_host.wr(7'h6A, 16'h0C22);
        i_alprr_host.wr(7'h6B, 16'h4002);
        i_alprr_host.wr(7'h64, 16'h0123);
        i_alprr_host.wr(7'h65, 16'h0200);
        i_alprr_host.rd(7'h6B, d);
        check("power", d, 16'h4002);
        check("conv", conv_on, 1'b1);
        check("refbuf", ref_on, 1'b0);
        check("dac", dac_on, 12'h800);
        check("ch01", {ch0, ch1}, 14'h0182);
        check("ch23", {ch2, ch3}, 14'h3FFF);
        check("temphys", {hb, ha, hl}, 24'h180810);
        check("upper_a", ua, 12'h123);
        check("lower_a", la, 12'h200);
        check("upper_b", ub, 12'hFFF);
        check("lower_b", lb, 12'hFFF);
        check("order_a", bad_a, 1'b1);
        check("order_b", bad_b, 1'b1);
        // Near-miss key must be ignored, exact key resets
        i_alprr_host.wr(7'h7C, 16'h6601);
        #1 check("spinone", srp, 1'b0);
        i_alprr_host.rd(7'h6B, d);
        check("spimiss", d, 16'h4002);
        i_alprr_host.wr(7'h7C, 16'h6600);
        #1 check("softpls", srp, 1'b1);
        check("nohard", hrp, 1'b0);
        i_alprr_host.rd(7'h64, d);
        check("spikey", d, 16'h07FF);
        i_alprr_host.rd(7'h6B, d);
        check("spipwr", d, 16'h0000);
        check("order_ok", bad_a, 1'b0);
        check("upb_dflt", ub, 12'h7FF);
        check("conv_off", conv_on, 1'b0);
        // DAC data lives outside this bank, so the bench may power a DAC straight after reset
        @(posedge clk) i2c_mode <= 1'b1;
        i_alprr_host.wr(7'h6B, 16'h4002);
        i_alprr_host.wr(7'h7C, 16'h005A);
        i_alprr_host.rd(7'h6B, d);
        check("i2crst", d, 16'h0000);
        // Second hardware reset in mid-run
        i_alprr_host.wr(7'h6B, 16'h4002);
        @(posedge clk) resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1 check("hardrst2", hrp, 1'b1);
        i_alprr_host.rd(7'h6B, d);
        check("hwpwr", d, 16'h0000);
        finish_test;
    end
endmodule
